// ===== common/ucm_pkg.sv
// Package: register map, field layouts and carrier types of the clocked master transmitter
package ucm_pkg;

    localparam int unsigned ADDR_W     = 8;
    localparam int unsigned DIV_W      = 16;
    localparam int unsigned CHAR_W     = 9;
    localparam int unsigned BITCNT_W   = 4;

    localparam logic [7:0]  OFS_CTRL   = 8'h00;
    localparam logic [7:0]  OFS_DIV    = 8'h04;
    localparam logic [7:0]  OFS_DATA   = 8'h08;
    localparam logic [7:0]  OFS_STATUS = 8'h0C;

    localparam int unsigned CTRL_W     = 12;
    localparam logic [11:0] CTRL_RST   = 12'h000;
    localparam logic [15:0] DIV_RST    = 16'h0000;
    localparam logic [3:0]  BITS_EIGHT = 4'h8;
    localparam logic [3:0]  BITS_NINE  = 4'h9;

    // Status word bit positions
    localparam int unsigned ST_READY   = 0;
    localparam int unsigned ST_SHIFT   = 1;
    localparam int unsigned ST_TXMODE  = 2;
    localparam int unsigned ST_PIN     = 3;

    // Control word, bit 11 down to bit 0
    typedef struct packed {
        logic transmit_interrupt_enable;
        logic wide_divisor_select;
        logic high_speed_select;
        logic continuous_receive_enable;
        logic single_receive_enable;
        logic clock_polarity_select;
        logic ninth_transmit_bit;
        logic nine_bit_transmit_enable;
        logic transmit_enable;
        logic serial_port_enable;
        logic clock_source_master;
        logic sync_mode;
    } ucm_ctrl_type;

    typedef struct packed {
        logic                nine;
        logic [CHAR_W-1:0]   data;
        logic [DIV_W-1:0]    div;
    } ucm_payload_type;

    typedef struct packed {
        logic pol;
        logic clk_drive;
        logic tx_mode;
    } ucm_cfg_type;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
    } ucm_apb_req_type;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } ucm_apb_rsp_type;

    typedef struct packed {
        logic clock_pin_o;
        logic clock_pin_oe;
        logic data_pin_o;
        logic data_pin_oe;
    } ucm_pin_type;

    typedef enum logic [1:0] {
        LS_IDLE  = 2'b00,
        LS_LEAD  = 2'b01,
        LS_TRAIL = 2'b10
    } ucm_link_state_type;

endpackage

// ===== hdl/ucm_sync_tx.sv
// Clocked master transmitter of the enhanced serial port, APB slave side and link side
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Function
// RULE_01: Two lines only, half duplex
// RULE_02: No start or stop bits
// RULE_03: Mode, master and port enable bits
// RULE_04: Both receive enables clear means transmit
// RULE_05: Master drives clock pin automatically
// RULE_06: Data changes on leading clock edge
// RULE_07: One clock per data bit only
// RULE_08: Polarity set: idle high, change falling
// RULE_09: Polarity clear: idle low, change rising
// RULE_10: Transmit enables data and clock drivers
// RULE_11: Write starts; waits while shifter busy
// RULE_12: Empty shifter loads at once, shifts
// RULE_13: Shift register not software visible
// RULE_14: Software set-up order before loading data
// RULE_15: Ninth bit sent with eight data
// RULE_16: Software sets interrupt enables if wanted
// RULE_17: Ready flag when holding empty, interrupt
// RULE_18: Least significant bit first, ninth last
////////////////////////////////////////////////////////////////////////////////
module ucm_sync_tx (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire ucm_pkg::ucm_apb_req_type apb_req,
    output ucm_pkg::ucm_apb_rsp_type      apb_rsp,
    input  wire logic                     link_clk,
    input  wire logic                     data_pin_i,
    output ucm_pkg::ucm_pin_type          pins,
    output logic                          tx_irq
);

    typedef struct packed {
        ucm_pkg::ucm_ctrl_type           ctrl;
        logic [ucm_pkg::DIV_W-1:0]       div;
        logic [ucm_pkg::CHAR_W-1:0]      hold;
        logic                            hold_nine;
        logic                            hold_full;
        ucm_pkg::ucm_payload_type        pay;
        logic                            req;
        logic                            ack_s1;
        logic                            ack_s2;
        logic                            busy_s1;
        logic                            busy_s2;
        logic                            pin_s1;
        logic                            pin_s2;
        ucm_pkg::ucm_cfg_type            cfg;
        ucm_pkg::ucm_apb_rsp_type        rsp;
        logic                            irq;
    } ucm_pstate_type;

    typedef struct packed {
        logic                            req_s1;
        logic                            req_s2;
        logic                            ack;
        ucm_pkg::ucm_cfg_type            cfg_s1;
        ucm_pkg::ucm_cfg_type            cfg_s2;
        ucm_pkg::ucm_link_state_type     state;
        logic [ucm_pkg::CHAR_W-1:0]      shift;
        logic [ucm_pkg::BITCNT_W-1:0]    bits;
        logic                            bits9;
        logic [ucm_pkg::DIV_W-1:0]       div;
        logic [ucm_pkg::DIV_W-1:0]       cnt;
        logic                            busy;
        ucm_pkg::ucm_pin_type            pin;
    } ucm_lstate_type;

    ucm_pstate_type p_reg;
    ucm_pstate_type p_next;
    ucm_lstate_type l_reg;
    ucm_lstate_type l_next;

    logic access;
    logic tx_mode;
    logic launch;

    ////////////////////////////////////////////////////////////////////////////
    // Register side, pclk domain
    always_comb begin
        p_next         = p_reg;
        p_next.ack_s1  = l_reg.ack;
        p_next.ack_s2  = p_reg.ack_s1;
        p_next.busy_s1 = l_reg.busy;
        p_next.busy_s2 = p_reg.busy_s1;
        p_next.pin_s1  = data_pin_i;
        p_next.pin_s2  = p_reg.pin_s1;
        access         = apb_req.psel && apb_req.penable && !p_reg.rsp.pready;
        // Clocked master transmit needs sync, master, port enable, tx enable
        tx_mode        = p_reg.ctrl.sync_mode && p_reg.ctrl.clock_source_master // see RULE_03
                         && p_reg.ctrl.serial_port_enable && p_reg.ctrl.transmit_enable
                         && !p_reg.ctrl.single_receive_enable                   // see RULE_04
                         && !p_reg.ctrl.continuous_receive_enable;
        p_next.cfg.tx_mode   = tx_mode;                                         // see RULE_10
        p_next.cfg.clk_drive = p_reg.ctrl.sync_mode && p_reg.ctrl.clock_source_master
                               && p_reg.ctrl.serial_port_enable                 // see RULE_05
                               && (p_reg.ctrl.transmit_enable || p_reg.ctrl.single_receive_enable
                                   || p_reg.ctrl.continuous_receive_enable);
        p_next.cfg.pol       = p_reg.ctrl.clock_polarity_select;
        // Hand the held character over once the shifter finished the last one
        launch = p_reg.hold_full && (p_reg.req == p_reg.ack_s2) && tx_mode;   // see RULE_11
        if (launch) begin
            p_next.pay.data = p_reg.hold;                                       // see RULE_12
            p_next.pay.nine = p_reg.hold_nine;
            p_next.pay.div  = p_reg.ctrl.wide_divisor_select ? p_reg.div : {8'h00, p_reg.div[7:0]};
            p_next.req      = !p_reg.req;
            p_next.hold_full = 1'b0;
        end
        p_next.rsp.pready  = access;
        p_next.rsp.pslverr = 1'b0;
        p_next.rsp.prdata  = 32'h0000_0000;
        if (access) begin
            unique case (apb_req.paddr)
                ucm_pkg::OFS_CTRL: begin
                    if (apb_req.pwrite) begin
                        p_next.ctrl = ucm_pkg::ucm_ctrl_type'(apb_req.pwdata[ucm_pkg::CTRL_W-1:0]);
                    end
                    p_next.rsp.prdata = {20'h0_0000, p_reg.ctrl};
                end
                ucm_pkg::OFS_DIV: begin
                    if (apb_req.pwrite) begin
                        p_next.div = apb_req.pwdata[ucm_pkg::DIV_W-1:0];
                    end
                    p_next.rsp.prdata = {16'h0000, p_reg.div};
                end
                ucm_pkg::OFS_DATA: begin
                    // Write wins over a same-cycle launch; ninth bit taken now
                    if (apb_req.pwrite) begin
                        p_next.hold      = {p_reg.ctrl.ninth_transmit_bit, apb_req.pwdata[7:0]}; // see RULE_15
                        p_next.hold_nine = p_reg.ctrl.nine_bit_transmit_enable;
                        p_next.hold_full = 1'b1;                                // see RULE_11
                    end
                    p_next.rsp.prdata = {23'h00_0000, p_reg.hold};
                end
                ucm_pkg::OFS_STATUS: begin
                    // Shift register itself has no address
                    p_next.rsp.prdata[ucm_pkg::ST_READY]  = !p_reg.hold_full;   // see RULE_13
                    p_next.rsp.prdata[ucm_pkg::ST_SHIFT]  = !p_reg.busy_s2 && (p_reg.req == p_reg.ack_s2);
                    p_next.rsp.prdata[ucm_pkg::ST_TXMODE] = tx_mode;
                    p_next.rsp.prdata[ucm_pkg::ST_PIN]    = p_reg.pin_s2;
                end
                default: begin
                    p_next.rsp.pslverr = 1'b1;
                end
            endcase
        end
        p_next.irq = !p_next.hold_full && p_next.ctrl.transmit_interrupt_enable; // see RULE_17
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p_reg      <= '0;
            p_reg.ctrl <= ucm_pkg::CTRL_RST;
            p_reg.div  <= ucm_pkg::DIV_RST;
        end else begin
            p_reg <= p_next;
        end
    end

    assign apb_rsp = p_reg.rsp;
    assign tx_irq  = p_reg.irq;

    ////////////////////////////////////////////////////////////////////////////
    // Link side, link_clk domain
    always_comb begin
        l_next        = l_reg;
        l_next.req_s1 = p_reg.req;
        l_next.req_s2 = l_reg.req_s1;
        l_next.cfg_s1 = p_reg.cfg;
        l_next.cfg_s2 = l_reg.cfg_s1;
        // Single data line, driven only while transmitting
        l_next.pin.data_pin_oe  = l_reg.cfg_s2.tx_mode;                         // see RULE_01
        l_next.pin.clock_pin_oe = l_reg.cfg_s2.clk_drive;                       // see RULE_05
        unique case (l_reg.state)
            ucm_pkg::LS_IDLE: begin
                l_next.pin.clock_pin_o = l_reg.cfg_s2.pol;                      // see RULE_08
                if (l_reg.cfg_s2.tx_mode && (l_reg.req_s2 != l_reg.ack)) begin
                    // Payload is stable until the ack returns; data bits only
                    l_next.pin.data_pin_o  = p_reg.pay.data[0];                 // see RULE_18
                    l_next.shift           = {1'b0, p_reg.pay.data[ucm_pkg::CHAR_W-1:1]};
                    l_next.bits9           = p_reg.pay.nine;
                    l_next.bits            = p_reg.pay.nine ? ucm_pkg::BITS_NINE : ucm_pkg::BITS_EIGHT; // see RULE_02
                    l_next.div             = p_reg.pay.div;
                    l_next.cnt             = p_reg.pay.div;
                    l_next.pin.clock_pin_o = !l_reg.cfg_s2.pol;                 // see RULE_06
                    l_next.state           = ucm_pkg::LS_LEAD;
                end
            end
            ucm_pkg::LS_LEAD: begin
                if (l_reg.cnt != '0) begin
                    l_next.cnt = l_reg.cnt - 1'b1;
                end else begin
                    l_next.cnt             = l_reg.div;
                    l_next.pin.clock_pin_o = l_reg.cfg_s2.pol;
                    // Last trailing edge ends the character, no extra clocks
                    if (l_reg.bits == 4'h1) begin                               // see RULE_07
                        l_next.state = ucm_pkg::LS_IDLE;
                        // Holding register may hand over only after the last bit
                        l_next.ack   = l_reg.req_s2;                            // see RULE_11
                    end else begin
                        l_next.bits  = l_reg.bits - 1'b1;
                        l_next.state = ucm_pkg::LS_TRAIL;
                    end
                end
            end
            ucm_pkg::LS_TRAIL: begin
                if (l_reg.cnt != '0) begin
                    l_next.cnt = l_reg.cnt - 1'b1;
                end else begin
                    // Leading edge: clock leaves idle, next bit goes out
                    l_next.cnt             = l_reg.div;
                    l_next.pin.clock_pin_o = !l_reg.cfg_s2.pol;                 // see RULE_09
                    l_next.pin.data_pin_o  = l_reg.shift[0];                    // see RULE_06
                    l_next.shift           = {1'b0, l_reg.shift[ucm_pkg::CHAR_W-1:1]};
                    l_next.state           = ucm_pkg::LS_LEAD;
                end
            end
            default: begin
                l_next.state = ucm_pkg::LS_IDLE;
            end
        endcase
        // Leaving transmit mode drops the character and parks the clock
        if (!l_reg.cfg_s2.tx_mode) begin
            l_next.state           = ucm_pkg::LS_IDLE;
            l_next.pin.clock_pin_o = l_reg.cfg_s2.pol;
            l_next.ack             = l_reg.req_s2;
        end
        l_next.busy = (l_next.state != ucm_pkg::LS_IDLE);
    end

    always_ff @(posedge link_clk or negedge presetn) begin
        if (!presetn) begin
            l_reg <= '0;
        end else begin
            l_reg <= l_next;
        end
    end

    assign pins = l_reg.pin;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    logic [4:0] tog_cnt;

    always_ff @(posedge link_clk or negedge presetn) begin
        if (!presetn) begin
            tog_cnt <= 5'h00;
        end else if (l_reg.busy) begin
            tog_cnt <= tog_cnt + 5'(l_next.pin.clock_pin_o != l_reg.pin.clock_pin_o);
        end else begin
            tog_cnt <= 5'(l_next.pin.clock_pin_o != l_reg.pin.clock_pin_o);
        end
    end

    chk_half_duplex: assert property (@(posedge link_clk) disable iff (!presetn) // see RULE_01
        l_reg.pin.data_pin_oe |-> $past(l_reg.cfg_s2.tx_mode))
        else $error("data pin driven outside transmit mode");

    chk_mode_decode: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_04
        (p_reg.ctrl.single_receive_enable || p_reg.ctrl.continuous_receive_enable) |=> !p_reg.cfg.tx_mode)
        else $error("transmit mode with a receive enable set");

    chk_idle_high: assert property (@(posedge link_clk) disable iff (!presetn) // see RULE_08
        (!l_reg.busy && $past(!l_reg.busy) && $past(l_reg.cfg_s2.pol)) |-> l_reg.pin.clock_pin_o)
        else $error("clock not idle high");

    chk_idle_low: assert property (@(posedge link_clk) disable iff (!presetn) // see RULE_09
        (!l_reg.busy && $past(!l_reg.busy) && !$past(l_reg.cfg_s2.pol)) |-> !l_reg.pin.clock_pin_o)
        else $error("clock not idle low");

    chk_data_on_lead: assert property (@(posedge link_clk) disable iff (!presetn) // see RULE_06
        (l_reg.busy && $changed(l_reg.pin.data_pin_o)) |-> (l_reg.pin.clock_pin_o != l_reg.cfg_s2.pol))
        else $error("data changed away from leading edge");

    chk_edge_count: assert property (@(posedge link_clk) disable iff (!presetn) // see RULE_07
        ($fell(l_reg.busy) && $past(l_reg.cfg_s2.tx_mode)) |-> (tog_cnt == (l_reg.bits9 ? 5'd18 : 5'd16)))
        else $error("wrong number of clock edges in a character");

    chk_hold_wait: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_11
        (p_reg.hold_full && (p_reg.req != p_reg.ack_s2)) |=> p_reg.hold_full)
        else $error("holding register released while shifter busy");

    chk_launch_now: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_12
        (p_reg.hold_full && (p_reg.req == p_reg.ack_s2) && p_reg.cfg.tx_mode && tx_mode)
        |=> (p_reg.req != $past(p_reg.req)))
        else $error("idle shifter not loaded at once");

    chk_lsb_first: assert property (@(posedge link_clk) disable iff (!presetn) // see RULE_18
        $rose(l_reg.busy) |-> (l_reg.pin.data_pin_o == $past(p_reg.pay.data[0])))
        else $error("first bit out is not the least significant");

    chk_ready_irq: assert property (@(posedge pclk) disable iff (!presetn) // see RULE_17
        p_reg.irq |-> (!p_reg.hold_full && p_reg.ctrl.transmit_interrupt_enable))
        else $error("interrupt without empty holding register");

    cov_launch: cover property (@(posedge pclk) disable iff (!presetn) launch);

    cov_nine_bit: cover property (@(posedge link_clk) disable iff (!presetn)
        $fell(l_reg.busy) && l_reg.bits9);

    cov_back_to_back: cover property (@(posedge pclk) disable iff (!presetn)
        p_reg.hold_full && (p_reg.req != p_reg.ack_s2));

    cov_pol_high: cover property (@(posedge link_clk) disable iff (!presetn)
        $rose(l_reg.busy) && l_reg.cfg_s2.pol);

endmodule // ucm_sync_tx

// ===== test/ucm_slave_model.sv
// Partner model: slave receiver on the clocked link, sampling at each trailing clock edge
`timescale 1ns/1ps
module ucm_slave_model (
    input  wire logic        clk_line,
    input  wire logic        dat_line,
    input  wire logic        pol,
    input  wire logic        clr,
    output logic [31:0]      bits,
    output logic [5:0]       cnt,
    output logic [7:0]       viol
);
    time t_lead;
    time t_dat;

    initial begin
        bits = 32'h0000_0000;
        cnt = 6'h00;
        viol = 8'h00;
        t_lead = 0;
        t_dat = 0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Trailing edge takes one bit, leading edge marks when data may move
    always @(clk_line or posedge clr) begin
        if (clr) begin
            bits = 32'h0000_0000;
            cnt = 6'h00;
            viol = 8'h00;
        end else if (clk_line === pol) begin
            // Data moved after the leading edge of this bit
            if (t_dat > t_lead) begin
                viol = viol + 8'h01;
            end
            bits[cnt[4:0]] = dat_line;
            cnt = cnt + 6'h01;
        end else begin
            t_lead = $time;
        end
    end

    // Last data change, judged at the trailing edge
    always @(dat_line) begin
        t_dat = $time;
    end
endmodule // ucm_slave_model

// ===== test/tb_usart_clocked_master_tx.sv
// Testbench: APB register tasks and character tests of the clocked master transmitter
`timescale 1ns/1ps
module tb_usart_clocked_master_tx;
    logic                     pclk;
    logic                     presetn;
    logic                     link_clk;
    logic                     data_pin_i;
    logic                     tx_irq;
    logic                     slave_clr;
    logic                     clk_held;
    logic                     dat_held;
    logic                     clk_line;
    logic                     dat_line;
    logic                     pol;
    logic                     err;
    logic [31:0]              rdata;
    logic [31:0]              s_bits;
    logic [5:0]               s_cnt;
    logic [7:0]               s_viol;
    ucm_pkg::ucm_apb_req_type apb_req;
    ucm_pkg::ucm_apb_rsp_type apb_rsp;
    ucm_pkg::ucm_pin_type     pins;
    int                       error_cnt;
    int                       samples_checked;
    int                       cyc;

    ucm_sync_tx ucm_sync_tx_i (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .link_clk(link_clk), .data_pin_i(data_pin_i), .pins(pins), .tx_irq(tx_irq));
    ucm_slave_model ucm_slave_model_i (.clk_line(clk_line), .dat_line(dat_line), .pol(pol), .clr(slave_clr),
        .bits(s_bits), .cnt(s_cnt), .viol(s_viol));

    always #2.5 pclk = ~pclk;
    initial begin
        #37;
        forever #80 link_clk = ~link_clk;
    end

    // Released lines show the inverse of their last driven level
    always @(posedge link_clk) begin
        if (pins.clock_pin_oe) clk_held <= pins.clock_pin_o;
        if (pins.data_pin_oe) dat_held <= pins.data_pin_o;
    end
    assign clk_line = pins.clock_pin_oe ? pins.clock_pin_o : ~clk_held;
    assign dat_line = pins.data_pin_oe ? pins.data_pin_o : ~dat_held;
    assign data_pin_i = dat_line;

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        apb_req.psel <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite <= wr;
        apb_req.paddr <= a;
        apb_req.pwdata <= wd;
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        // Look at the answer between edges, where it has settled
        do begin
            @(negedge pclk);
        end while (apb_rsp.pready !== 1'b1);
        rdata = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        @(posedge pclk);
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        @(posedge pclk);
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, rdata & msk, exp);
    endtask

    task clr_slave();
        slave_clr <= 1'b1;
        @(posedge pclk);
        slave_clr <= 1'b0;
        @(posedge pclk);
    endtask

    task wait_bits(input int n, input logic [31:0] exp);
        int k;
        logic [31:0] msk;
        k = 0;
        msk = (32'h0000_0001 << n) - 32'h0000_0001;
        while (s_cnt !== n[5:0] && k < 4000) begin
            @(posedge pclk);
            k++;
        end
        repeat (1500) @(posedge pclk);
        chk("bit count", {26'h000_0000, s_cnt}, n);
        chk("char bits", s_bits & msk, exp);
        chk("data moves", {24'h00_0000, s_viol}, 32'h0000_0000);
        chk("idle clock", {31'h0, pins.clock_pin_o}, {31'h0, pol});
    endtask

    task results();
        $display("Checks made %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        link_clk = 1'b0;
        presetn = 1'b0;
        apb_req = '0;
        slave_clr = 1'b0;
        pol = 1'b0;
        clk_held = 1'b0;
        dat_held = 1'b0;
        error_cnt = 0;
        samples_checked = 0;
        cyc = 0;
        // Reset spans edges of both clocks
        repeat (2) @(posedge link_clk);
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc(ucm_pkg::OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_0000, "ctrl reset");
        rdc(ucm_pkg::OFS_DIV, 32'hFFFF_FFFF, 32'h0000_0000, "div reset");
        rdc(ucm_pkg::OFS_STATUS, 32'h0000_0007, 32'h0000_0003, "status reset");
        chk("pins reset", {28'h000_0000, pins}, 32'h0000_0000);
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk("unmapped", {31'h0, err}, 32'h0000_0001);
        // Divisor first, then mode bits, then transmit enable
        apb(1'b1, ucm_pkg::OFS_DIV, 32'h0000_0001);
        apb(1'b1, ucm_pkg::OFS_CTRL, 32'h0000_0007);
        apb(1'b1, ucm_pkg::OFS_CTRL, 32'h0000_000F);
        repeat (200) @(posedge pclk);
        rdc(ucm_pkg::OFS_CTRL, 32'h0000_0FFF, 32'h0000_000F, "ctrl value");
        chk("tx drivers", {29'h0, pins.clock_pin_oe, pins.data_pin_oe, pins.clock_pin_o}, 32'h0000_0006);
        rdc(ucm_pkg::OFS_STATUS, 32'h0000_0007, 32'h0000_0007, "tx mode");
        for (int m = 1; m < 4; m++) begin
            apb(1'b1, ucm_pkg::OFS_CTRL, 32'h0000_000F | (m << 7));
            repeat (200) @(posedge pclk);
            rdc(ucm_pkg::OFS_STATUS, 32'h0000_0004, 32'h0000_0000, "rx mode");
            chk("rx drivers", {30'h0, pins.clock_pin_oe, pins.data_pin_oe}, 32'h0000_0002);
        end
        apb(1'b1, ucm_pkg::OFS_CTRL, 32'h0000_000F);
        repeat (200) @(posedge pclk);
        clr_slave();
        // Two characters, the second held while the first shifts
        apb(1'b1, ucm_pkg::OFS_DATA, 32'h0000_00A5);
        repeat (250) @(posedge pclk);
        chk("shift started", {31'h0, s_cnt != 6'h00}, 32'h0000_0001);
        rdata = 32'h0000_0000;
        for (int k = 0; k < 400 && rdata[0] !== 1'b1; k++) apb(1'b0, ucm_pkg::OFS_STATUS, 32'h0000_0000);
        apb(1'b1, ucm_pkg::OFS_DATA, 32'h0000_003C);
        rdc(ucm_pkg::OFS_STATUS, 32'h0000_0003, 32'h0000_0000, "holding waits");
        wait_bits(16, 32'h0000_3CA5);
        rdc(ucm_pkg::OFS_STATUS, 32'h0000_000F, 32'h0000_0007, "drained");
        // Nine bits, clock idle high, ready interrupt enabled
        pol <= 1'b1;
        apb(1'b1, ucm_pkg::OFS_CTRL, 32'h0000_087F);
        repeat (200) @(posedge pclk);
        chk("irq empty", {31'h0, tx_irq}, 32'h0000_0001);
        clr_slave();
        apb(1'b1, ucm_pkg::OFS_DATA, 32'h0000_005A);
        // Second character waits in the holding register
        apb(1'b1, ucm_pkg::OFS_DATA, 32'h0000_005A);
        repeat (2) @(posedge pclk);
        chk("irq full", {31'h0, tx_irq}, 32'h0000_0000);
        wait_bits(18, 32'h0002_B55A);
        rdc(ucm_pkg::OFS_DATA, 32'h0000_01FF, 32'h0000_015A, "data held");
        apb(1'b1, ucm_pkg::OFS_CTRL, 32'h0000_000B);
        repeat (200) @(posedge pclk);
        chk("port off", {30'h0, pins.clock_pin_oe, pins.data_pin_oe}, 32'h0000_0000);
        results();
    end
endmodule // tb_usart_clocked_master_tx
